// ===== mebc_regs.svh
// Operation
// [R1] Multiplexed low address/data, separate high address
// [R2] Latch strobe marks low address on lines
// [R3] Fetch/const use program strobe; read, write
// [R4] Reset loads long six-period data cycles
// [R5] Firmware should retune cycle counts after reset
// [R6] Fetched code bytes go into prefetch queue
// [R7] Constant and data reads bypass the queue
// [R8] Cycle counts apply to every address range
// [R9] Separate counts for program and read reads
// [R10] Fetch cycle may abort when byte unneeded
// [R11] Only queue stalls lengthen fetch, never reads
// [R12] Writes go straight out, one count
// [R13] Bus always internal, pins only larger package
// [R14] Write wait bits 5:4, 4-7 periods, default 10
// [R15] Read wait bits 3:2, 4-7 periods, default 10
// [R16] Code wait bits 1:0, 3-6, const minimum four
// [R17] Bits 7/6 queue/cache enables, reset EBh
// [R18] Cycles last exactly programmed periods, strobe data-only
`ifndef MEBC_REGS_SVH
`define MEBC_REGS_SVH

// Register byte offsets on the Wishbone slave
`define MEBC_BTC_OFS      4'h0
`define MEBC_STAT_OFS     4'h4

// Bus timing control reset value and fields
`define MEBC_BTC_RESET    8'hEB
`define MEBC_QUEUE_EN_BIT      7
`define MEBC_CACHE_EN_BIT      6
`define MEBC_WR_WAIT_MSB       5
`define MEBC_WR_WAIT_LSB       4
`define MEBC_RD_WAIT_MSB       3
`define MEBC_RD_WAIT_LSB       2
`define MEBC_CODE_WAIT_MSB     1
`define MEBC_CODE_WAIT_LSB     0

// Cycle length bases in core clock periods
`define MEBC_DATA_BASE    4'h4
`define MEBC_CODE_BASE    4'h3
`define MEBC_CONST_MIN    4'h4
`define MEBC_CODE_WAIT_ZERO 2'h0
// Length every kind gets with the reset register value
`define MEBC_LONG_LEN     4'h6

`endif

// ===== mebc_pkg.sv
`default_nettype none
package mebc_pkg;

  // Transfer kinds requested by the core
  typedef enum logic [1:0] {
    MEBC_K_FETCH = 2'b00,
    MEBC_K_CONST = 2'b01,
    MEBC_K_XRD   = 2'b10,
    MEBC_K_XWR   = 2'b11
  } mebc_kind_e;

  // Bus cycle phases
  typedef enum logic [1:0] {
    MEBC_ST_IDLE = 2'b00,
    MEBC_ST_ADDR = 2'b01,
    MEBC_ST_DATA = 2'b10
  } mebc_state_e;

  // One request from the core
  typedef struct packed {
    mebc_kind_e  kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mebc_req_s;

  // Bus outputs toward the memory module and pads
  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] ad_out;
    logic       ad_oe;
    logic       latch_strobe;
    logic       program_strobe_n;
    logic       read_strobe_n;
    logic       write_strobe_n;
  } mebc_bus_s;

endpackage
`default_nettype wire

// ===== mebc_cyc_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Period counter for one bus cycle; length is latched at start
module mebc_cyc_timer #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] len_i,
  input  wire logic         hold_i,
  input  wire logic         kill_i,
  output logic      [W-1:0] cnt_o,
  output logic      [W-1:0] len_o,
  output logic              last_o
);

  logic [W-1:0] cnt_q;  // Current period, zero when idle
  logic [W-1:0] len_q;  // Latched length of this cycle

  // Length is frozen so a register write mid-cycle cannot bend it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= '0;
    end else if (start_i) begin
      len_q <= len_i;
    end
  end

  // Count periods; a hold freezes the count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= W'(1);
    end else if (kill_i || last_o) begin
      cnt_q <= '0;
    end else if (cnt_q != '0 && !hold_i) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign last_o = (cnt_q != '0) && (cnt_q == len_q) && !hold_i;
  assign cnt_o  = cnt_q;
  assign len_o  = len_q;

endmodule
`default_nettype wire

// ===== mebc_bus.sv
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mebc_regs.svh"
// Multiplexed external bus cycle engine with Wishbone timing register
module mebc_bus
  import mebc_pkg::*;
#(
  parameter bit EXT_BUS_PINS = 1'b1  // Larger package brings bus to pads
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // Core request side
  input  wire logic        req_valid_i,
  input  wire mebc_req_s   req_i,
  output logic             req_ready_o,
  input  wire logic        abort_i,
  input  wire logic        stall_i,
  output logic             queue_wr_o,
  output logic      [7:0]  queue_data_o,
  output logic             core_rd_valid_o,
  output logic      [7:0]  core_rd_data_o,
  output logic             done_o,
  output logic             queue_en_o,
  output logic             cache_en_o,
  // Multiplexed bus
  output mebc_bus_s        bus_o,
  input  wire logic [7:0]  bus_ad_i,
  output logic             ext_pad_en_o
);

  // Registers and state
  logic [7:0]  btc_q;        // Bus timing control
  mebc_state_e state_q;      // Cycle phase
  mebc_kind_e  kind_q;       // Kind of the running cycle
  logic [15:0] addr_q;       // Address of the running cycle
  logic [7:0]  wdata_q;      // Write byte of the running cycle
  logic        ack_q;        // Wishbone acknowledge
  logic [31:0] rdat_q;       // Wishbone read data
  logic        queue_wr_q;   // Queue write pulse
  logic [7:0]  queue_data_q; // Queue write byte
  logic        rd_valid_q;   // Direct read pulse
  logic [7:0]  rd_data_q;    // Direct read byte
  logic        done_q;       // Cycle end pulse
  logic        aborted_q;    // Last cycle was aborted

  // Combinational helpers
  logic        start;        // Request accepted this edge
  logic        hold;         // Queue reload stall in force
  logic        kill;         // Fetch cycle abandoned
  logic        last;         // Final period of a cycle
  logic [3:0]  len_d;        // Length of the request offered
  logic [3:0]  cnt;          // Current period
  logic [3:0]  len_run;      // Length of the running cycle
  logic        busy;         // A cycle is on the bus
  logic        wb_req;       // Fresh Wishbone access
  logic [1:0]  wr_wait;      // Write wait code
  logic [1:0]  rd_wait;      // Read wait code
  logic [1:0]  code_wait;    // Code wait code

  assign wr_wait   = btc_q[`MEBC_WR_WAIT_MSB:`MEBC_WR_WAIT_LSB];
  assign rd_wait   = btc_q[`MEBC_RD_WAIT_MSB:`MEBC_RD_WAIT_LSB];
  assign code_wait = btc_q[`MEBC_CODE_WAIT_MSB:`MEBC_CODE_WAIT_LSB];
  assign busy = (state_q != MEBC_ST_IDLE);

  // Wishbone handshake: answer one cycle after the strobe, drop next
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // Timing register; reset gives long cycles and both enables on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btc_q <= `MEBC_BTC_RESET;                            // R4 R17
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `MEBC_BTC_OFS) begin
      btc_q <= wb_dat_i[7:0];
    end
  end

  // Read mux; unmapped offsets read as zero and writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == `MEBC_BTC_OFS) begin
        rdat_q <= {24'h00_0000, btc_q};
      end else if (wb_adr_i == `MEBC_STAT_OFS) begin
        rdat_q <= {16'h0000, rd_data_q, 4'h0, aborted_q, kind_q, busy};
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // One count per kind, never per address region
  always_comb begin
    case (req_i.kind)                                        // R8 R9
      MEBC_K_XWR: begin
        len_d = `MEBC_DATA_BASE + {2'b00, wr_wait};          // R12 R14
      end
      MEBC_K_XRD: begin
        len_d = `MEBC_DATA_BASE + {2'b00, rd_wait};          // R15
      end
      MEBC_K_CONST: begin
        // Constant loads cannot run at the shortest code setting
        if (code_wait == `MEBC_CODE_WAIT_ZERO) begin
          len_d = `MEBC_CONST_MIN;                           // R16
        end else begin
          len_d = `MEBC_CODE_BASE + {2'b00, code_wait};
        end
      end
      default: begin
        len_d = `MEBC_CODE_BASE + {2'b00, code_wait};        // R16
      end
    endcase
  end

  // Accept only between cycles
  assign req_ready_o = !busy;
  assign start       = req_valid_i && !busy;

  // Stalls only stretch fetches, and only while the strobe is low
  assign hold = busy && kind_q == MEBC_K_FETCH && stall_i && // R11
                state_q == MEBC_ST_DATA;

  // Abort is honoured only with queue or cache logic enabled
  assign kill = busy && kind_q == MEBC_K_FETCH && abort_i && // R10
                (btc_q[`MEBC_QUEUE_EN_BIT] || btc_q[`MEBC_CACHE_EN_BIT]);

  mebc_cyc_timer #(
    .W (4)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start),
    .len_i   (len_d),
    .hold_i  (hold),
    .kill_i  (kill),
    .cnt_o   (cnt),
    .len_o   (len_run),
    .last_o  (last)
  );

  // Capture the request for the whole cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_q  <= MEBC_K_FETCH;
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (start) begin
      kind_q  <= req_i.kind;
      addr_q  <= req_i.addr;
      wdata_q <= req_i.wdata;
    end
  end

  // Phase sequencing: one address period then the data phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MEBC_ST_IDLE;
    end else begin
      case (state_q)
        MEBC_ST_IDLE: begin
          if (start) begin
            state_q <= MEBC_ST_ADDR;
          end
        end
        MEBC_ST_ADDR: begin
          if (kill) begin
            state_q <= MEBC_ST_IDLE;
          end else begin
            state_q <= MEBC_ST_DATA;
          end
        end
        MEBC_ST_DATA: begin
          if (last || kill) begin
            state_q <= MEBC_ST_IDLE;                         // R18
          end
        end
        default: begin
          state_q <= MEBC_ST_IDLE;
        end
      endcase
    end
  end

  // Fetched bytes land in the queue; an aborted fetch writes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      queue_wr_q   <= 1'b0;
      queue_data_q <= 8'h00;
    end else begin
      queue_wr_q <= last && kind_q == MEBC_K_FETCH && !kill; // R6
      if (last && kind_q == MEBC_K_FETCH) begin
        queue_data_q <= bus_ad_i;
      end
    end
  end

  // Constant and data reads go straight to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_valid_q <= last && (kind_q == MEBC_K_CONST ||       // R7
                             kind_q == MEBC_K_XRD);
      if (last && (kind_q == MEBC_K_CONST || kind_q == MEBC_K_XRD)) begin
        rd_data_q <= bus_ad_i;
      end
    end
  end

  // End of cycle and abort record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q    <= 1'b0;
      aborted_q <= 1'b0;
    end else begin
      done_q <= last || kill;
      if (last || kill) begin
        aborted_q <= kill;
      end
    end
  end

  assign queue_wr_o      = queue_wr_q;
  assign queue_data_o    = queue_data_q;
  assign core_rd_valid_o = rd_valid_q;
  assign core_rd_data_o  = rd_data_q;
  assign done_o          = done_q;
  assign queue_en_o      = btc_q[`MEBC_QUEUE_EN_BIT];        // R17
  assign cache_en_o      = btc_q[`MEBC_CACHE_EN_BIT];

  // Pin decode from registered phase; high address stands all cycle
  always_comb begin
    bus_o.addr_hi          = busy ? addr_q[15:8] : 8'h00;    // R1
    bus_o.latch_strobe     = (state_q == MEBC_ST_ADDR);      // R2
    bus_o.ad_oe            = (state_q == MEBC_ST_ADDR) ||
                             (state_q == MEBC_ST_DATA && kind_q == MEBC_K_XWR);
    bus_o.ad_out           = (state_q == MEBC_ST_ADDR) ? addr_q[7:0] : wdata_q;
    bus_o.program_strobe_n = !(state_q == MEBC_ST_DATA &&    // R3
                               (kind_q == MEBC_K_FETCH || kind_q == MEBC_K_CONST));
    bus_o.read_strobe_n    = !(state_q == MEBC_ST_DATA && kind_q == MEBC_K_XRD);
    bus_o.write_strobe_n   = !(state_q == MEBC_ST_DATA && kind_q == MEBC_K_XWR);
  end

  // Memory module is always wired; pads only on the larger package
  assign ext_pad_en_o = EXT_BUS_PINS;                        // R13

  // Period counter seen by the checks below
  logic [3:0] per_q;       // Periods since the cycle began
  logic       stalled_q;   // A stall stretched this cycle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_q     <= 4'h0;
      stalled_q <= 1'b0;
    end else if (start) begin
      per_q     <= 4'h1;
      stalled_q <= 1'b0;
    end else if (busy) begin
      per_q     <= per_q + 4'h1;
      stalled_q <= stalled_q || hold;
    end
  end

  property p_reset_btc;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> btc_q == `MEBC_BTC_RESET && len_d >= `MEBC_LONG_LEN;
  endproperty
  a_reset_btc: assert property (p_reset_btc) else $error("timing register not at reset value"); // R4

  property p_hi_addr;
    @(posedge clk_i) disable iff (rst_i)
      start ##1 busy [*3] |-> bus_o.addr_hi == $past(req_i.addr[15:8], 3);
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("high address not held"); // R1

  property p_latch_addr;
    @(posedge clk_i) disable iff (rst_i)
      start |=> bus_o.latch_strobe && bus_o.ad_oe && bus_o.ad_out == $past(req_i.addr[7:0])
        && bus_o.program_strobe_n && bus_o.read_strobe_n && bus_o.write_strobe_n;
  endproperty
  a_latch_addr: assert property (p_latch_addr) else $error("address phase wrong"); // R2

  property p_write_strobe;
    @(posedge clk_i) disable iff (rst_i)
      !bus_o.write_strobe_n |-> kind_q == MEBC_K_XWR && bus_o.ad_oe && bus_o.ad_out == wdata_q;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe misused"); // R3

  property p_fetch_queue;
    @(posedge clk_i) disable iff (rst_i)
      last && kind_q == MEBC_K_FETCH && !kill |=> queue_wr_o && !core_rd_valid_o
        && queue_data_o == $past(bus_ad_i);
  endproperty
  a_fetch_queue: assert property (p_fetch_queue) else $error("fetch byte missed queue"); // R6

  property p_read_bypass;
    @(posedge clk_i) disable iff (rst_i)
      last && kind_q inside {MEBC_K_CONST, MEBC_K_XRD} |=> core_rd_valid_o && !queue_wr_o;
  endproperty
  a_read_bypass: assert property (p_read_bypass) else $error("read byte not bypassed"); // R7

  property p_abort_fetch;
    @(posedge clk_i) disable iff (rst_i)
      kill |-> kind_q == MEBC_K_FETCH ##1 !busy && done_o && !queue_wr_o;
  endproperty
  a_abort_fetch: assert property (p_abort_fetch) else $error("abort handling wrong"); // R10

  property p_no_read_stall;
    @(posedge clk_i) disable iff (rst_i)
      busy && kind_q != MEBC_K_FETCH && !last |=> cnt == $past(cnt) + 4'h1;
  endproperty
  a_no_read_stall: assert property (p_no_read_stall) else $error("stall on non-fetch cycle"); // R11

  property p_write_len;
    @(posedge clk_i) disable iff (rst_i)
      start && req_i.kind == MEBC_K_XWR |-> len_d == `MEBC_DATA_BASE + {2'b00, wr_wait};
  endproperty
  a_write_len: assert property (p_write_len) else $error("write length wrong"); // R14

  property p_code_len;
    @(posedge clk_i) disable iff (rst_i)
      start && req_i.kind == MEBC_K_CONST && code_wait == `MEBC_CODE_WAIT_ZERO |=> len_run == `MEBC_CONST_MIN;
  endproperty
  a_code_len: assert property (p_code_len) else $error("constant load too short"); // R16

  property p_exact_len;
    @(posedge clk_i) disable iff (rst_i)
      last && !stalled_q && !hold |-> per_q == len_run ##1 !busy;
  endproperty
  a_exact_len: assert property (p_exact_len) else $error("cycle length wrong"); // R18

  c_fetch: cover property (@(posedge clk_i) disable iff (rst_i) queue_wr_o);
  c_write: cover property (@(posedge clk_i) disable iff (rst_i) last && kind_q == MEBC_K_XWR);
  c_abort: cover property (@(posedge clk_i) disable iff (rst_i) kill);
  c_stall: cover property (@(posedge clk_i) disable iff (rst_i) hold ##1 last);

endmodule
`default_nettype wire

// ===== mebc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-end memory on the multiplexed bus; answers combinationally
module mebc_mem_model
  import mebc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire mebc_bus_s bus_i,
  output logic     [7:0] bus_ad_o
);
  logic [7:0]  lo_q = 8'h00;   // Low address captured at latch strobe
  logic [7:0]  idle_q = 8'h00; // Released-line filler
  logic [15:0] a;              // Full address of the cycle
  logic        rd;             // A read strobe is low
  logic [7:0]  mem [65536];    // Byte storage

  // Untouched bytes hold a pattern the bench can predict
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i >> 8) ^ 8'(i) ^ 8'h3C;
    end
  end

  assign a = {bus_i.addr_hi, lo_q};
  assign rd = !bus_i.program_strobe_n || !bus_i.read_strobe_n;
  // Released lines toggle so a stale byte never looks valid
  assign bus_ad_o = rd ? mem[a] : idle_q;

  // Capture low address before the lines turn to data
  always @(posedge clk_i) begin
    if (bus_i.latch_strobe) begin
      lo_q <= bus_i.ad_out;
    end
    idle_q <= ~bus_ad_o;
    if (!bus_i.write_strobe_n && bus_i.ad_oe) begin
      mem[a] <= bus_i.ad_out;
    end
  end
endmodule
`default_nettype wire

// ===== mebc_bus_test.sv
`timescale 1ns/10ps
`default_nettype none
// Directed bench: register access and every bus cycle kind
module mebc_bus_test;
  import mebc_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        req_valid_i = 1'h0, abort_i = 1'h0, stall_i = 1'h0;
  mebc_req_s   req_i = '0;
  logic        wb_ack_o, req_ready_o, queue_wr_o, core_rd_valid_o, done_o;
  logic        queue_en_o, cache_en_o, ext_pad_en_o;
  logic [31:0] wb_dat_o;
  logic [7:0]  queue_data_o, core_rd_data_o, bus_ad_i;
  mebc_bus_s   bus_o;
  int          error_cnt = 0, checks_done = 0, cyc_cnt = 0;

  mebc_bus i_mebc_bus (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .abort_i(abort_i), .stall_i(stall_i), .queue_wr_o(queue_wr_o),
    .queue_data_o(queue_data_o), .core_rd_valid_o(core_rd_valid_o), .core_rd_data_o(core_rd_data_o),
    .done_o(done_o), .queue_en_o(queue_en_o), .cache_en_o(cache_en_o), .bus_o(bus_o), .bus_ad_i(bus_ad_i),
    .ext_pad_en_o(ext_pad_en_o));
  mebc_mem_model i_mebc_mem_model (.clk_i(clk_i), .bus_i(bus_o), .bus_ad_o(bus_ad_i));

  // 125 MHz core clock
  always #4 clk_i = ~clk_i;

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Expected byte of an address never written
  function automatic logic [7:0] fd(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3C;
  endfunction

  // One classic Wishbone cycle; waits for ack, then releases
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  // One bus cycle; en is accept-to-done count, i.e. periods plus one
  task automatic op(input mebc_kind_e k, input logic [15:0] a, input logic [7:0] wd,
                    input logic [7:0] ed, input int en, input bit stl, input bit abt);
    int n, stb, bad, lat;
    logic [2:0] m, s;
    logic pf, cr;
    logic [7:0] d;
    n = 0; stb = 0; bad = 0; lat = 0; pf = 1'h0; cr = 1'h0; d = 8'h00;
    m = (k == MEBC_K_XRD) ? 3'h2 : (k == MEBC_K_XWR) ? 3'h1 : 3'h4;
    @(posedge clk_i);
    req_valid_i <= 1'h1;
    req_i <= '{kind: k, addr: a, wdata: wd};
    do @(negedge clk_i); while (req_ready_o !== 1'h1);
    @(posedge clk_i);
    req_valid_i <= 1'h0;
    while (n < 40) begin
      @(negedge clk_i);
      n++;
      s = ~{bus_o.program_strobe_n, bus_o.read_strobe_n, bus_o.write_strobe_n};
      lat += int'(bus_o.latch_strobe);
      if (bus_o.latch_strobe && bus_o.ad_out !== a[7:0]) bad++;
      // The bus is already idle in the cycle that reports the end
      if (done_o !== 1'h1 && bus_o.addr_hi !== a[15:8]) bad++;
      if ((s & ~m) != 3'h0) bad++;
      if ((s & m) != 3'h0) begin
        stb++;
        if (bus_o.ad_oe !== (k == MEBC_K_XWR)) bad++;
        if (k == MEBC_K_XWR && bus_o.ad_out !== wd) bad++;
      end
      if (queue_wr_o === 1'h1) begin
        pf = 1'h1;
        d = queue_data_o;
      end
      if (core_rd_valid_o === 1'h1) begin
        cr = 1'h1;
        d = core_rd_data_o;
      end
      if (done_o === 1'h1) break;
      @(posedge clk_i);
      stall_i <= stl && (n == 2 || n == 3);
      abort_i <= abt && n == 1;
    end
    check(n, en);
    check(lat, 1);
    check(bad, 0);
    if (en > 3) check(stb, en - 2);
    check(pf, k == MEBC_K_FETCH && en > 3);
    check(cr, k == MEBC_K_CONST || k == MEBC_K_XRD);
    if (k != MEBC_K_XWR && en > 3) check(d, ed);
  endtask

  // Reset value, enables, pad enable, unmapped offset
  task automatic t_reset();
    logic [31:0] r;
    wb(1'h1, 4'hC, 32'h00000011, r);
    wb(1'h0, 4'hC, 32'h0, r);
    check(r, 32'h0);
    wb(1'h0, 4'h0, 32'h0, r);
    check(r, 32'h000000EB);
    check({queue_en_o, cache_en_o}, 2'h3);
    check(ext_pad_en_o, 1'h1);
    $display("test reset done");
  endtask

  // All kinds at reset timing: six periods
  task automatic t_default();
    op(MEBC_K_XWR, 16'h12A4, 8'h5E, 8'h00, 7, 0, 0);
    op(MEBC_K_XRD, 16'h12A4, 8'h00, 8'h5E, 7, 0, 0);
    op(MEBC_K_FETCH, 16'h3456, 8'h00, fd(16'h3456), 7, 0, 0);
    op(MEBC_K_CONST, 16'h789A, 8'h00, fd(16'h789A), 7, 0, 0);
    $display("test default timing done");
  endtask

  // Every code of every wait field; read and write codes differ
  task automatic t_codes();
    logic [31:0] r, v;
    logic [1:0] c;
    logic [15:0] a;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      a = {c, 6'h15, ~c, 6'h2B};
      v = {24'h0, 2'h3, c, ~c, c};
      wb(1'h1, 4'h0, v, r);
      wb(1'h0, 4'h0, 32'h0, r);
      check(r, v);
      op(MEBC_K_XWR, a, {c, 6'h21}, 8'h00, 5 + i, 0, 0);
      op(MEBC_K_XRD, a, 8'h00, {c, 6'h21}, 8 - i, 0, 0);
      op(MEBC_K_FETCH, a, 8'h00, {c, 6'h21}, 4 + i, 0, 0);
      op(MEBC_K_CONST, a ^ 16'h0101, 8'h00, fd(a ^ 16'h0101), (i == 0) ? 5 : 4 + i, 0, 0);
    end
    $display("test wait codes done");
  endtask

  // Equal code and read lengths; stall stretches only fetches
  task automatic t_stall();
    logic [31:0] r;
    wb(1'h1, 4'h0, 32'h000000E6, r);
    op(MEBC_K_FETCH, 16'h2233, 8'h00, fd(16'h2233), 6, 0, 0);
    op(MEBC_K_XRD, 16'h2233, 8'h00, fd(16'h2233), 6, 0, 0);
    op(MEBC_K_FETCH, 16'h2233, 8'h00, fd(16'h2233), 8, 1, 0);
    op(MEBC_K_XRD, 16'h2233, 8'h00, fd(16'h2233), 6, 1, 0);
    $display("test stall done");
  endtask

  // Fetch abort; ignored on data reads and with both enables off
  task automatic t_abort();
    logic [31:0] r;
    op(MEBC_K_FETCH, 16'h4455, 8'h00, fd(16'h4455), 3, 0, 1);
    // Status: last direct byte from the stalled read, aborted fetch, idle
    wb(1'h0, 4'h4, 32'h0, r);
    check(r, {16'h0000, fd(16'h2233), 8'h08});
    op(MEBC_K_XRD, 16'h4455, 8'h00, fd(16'h4455), 6, 0, 1);
    wb(1'h1, 4'h0, 32'h00000026, r);
    op(MEBC_K_FETCH, 16'h4455, 8'h00, fd(16'h4455), 6, 0, 1);
    check({queue_en_o, cache_en_o}, 2'h0);
    $display("test abort done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset for ten cycles, then run each test in turn
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_default();
    t_codes();
    t_stall();
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
